// File: rtl/pac_pkg.sv
// Constants and types for the pager address code converter
package pac_pkg;
  // ****************
  // Character codes
  // ****************
  localparam logic [7:0] CH_0 = 8'h30; // Digit zero
  localparam logic [7:0] CH_9 = 8'h39; // Digit nine
  localparam logic [7:0] CH_A = 8'h41; // First standard letter
  localparam logic [7:0] CH_E = 8'h45; // Standard any-phase
  localparam logic [7:0] CH_I = 8'h49; // Standard all-phase
  localparam logic [7:0] CH_L = 8'h4C; // Last standard letter
  localparam logic [7:0] CH_P = 8'h50; // First extension letter
  localparam logic [7:0] CH_S = 8'h53; // Last extension letter
  localparam logic [7:0] CH_U = 8'h55; // First explicit letter
  localparam logic [7:0] CH_X = 8'h58; // Last single-phase letter
  localparam logic [7:0] CH_Y = 8'h59; // Explicit any-phase
  localparam logic [7:0] CH_Z = 8'h5A; // Explicit all-phase
  // ****************
  // Address limits
  // ****************
  localparam int ACC_W = 34; // Holds any ten digit value
  localparam logic [ACC_W-1:0] ADDR_MIN = 34'h0_0000_0001;
  localparam logic [ACC_W-1:0] ADDR_MAX = 34'h1_4020_0FFE;
  localparam logic [ACC_W-1:0] ONE_LIM = 34'h0_001E_FFFF;
  localparam logic [ACC_W-1:0] TWO_LIM = 34'h0_0020_1000;
  localparam logic [20:0] SHORT_OFS = 21'h00_8000; // Short word offset
  // ****************
  // Field lengths and values
  // ****************
  localparam logic [3:0] LEN_SHORT = 4'h7;
  localparam logic [3:0] LEN_L12 = 4'h9;
  localparam logic [3:0] LEN_LONG = 4'hA;
  localparam logic [3:0] LEN_OVER = 4'hB; // Saturation count
  localparam logic [2:0] PRE_BATT = 3'h1; // Battery digit only
  localparam logic [2:0] PRE_FULL = 3'h4; // Frame plus battery
  localparam logic [2:0] PRE_OVER = 3'h5; // Saturation count
  localparam logic [3:0] BATT_MAX = 4'h7;
  localparam logic [2:0] BATT_DEF = 3'h4;
  localparam logic [9:0] FRAME_MAX = 10'h07F;
  localparam int PH_LSB = 2; // Phase field position
  localparam int FR_LSB = 4; // Frame field position
  // ****************
  // Types
  // ****************
  typedef enum logic [1:0] {CLS_SHORT = 2'h0, CLS_L12 = 2'h1,
                            CLS_LONG = 2'h2} addr_class_e;
  typedef enum logic [1:0] {DEV_SINGLE = 2'h0, DEV_ANY = 2'h1,
                            DEV_ALL = 2'h2} dev_class_e;
  typedef enum logic [3:0] {PS_HEAD = 4'h1, PS_PRE = 4'h2,
                            PS_ADDR = 4'h4, PS_BAD = 4'h8} parse_e;
endpackage : pac_pkg

// File: rtl/pac_conv.sv
// Pager address code text to over-the-air field converter
//
// What this block does
// - Type letter only A-L or U-Z
// - Standard form: optional battery digit, default 4
// - Explicit form: optional frame and battery, else unknown
// - Accept P-S extension before ten digit code
// - Digit count gives address class
// - Address range and one/two word limits
// - Display shortest form, standard letter preferred
// - Phase is adjusted address bits 3:2
// - Frame is adjusted address bits 10:4
// - Subtract letter position within group first
// - A-D single, E-H any, I-L all phase
// - U-X fixed phases 0-3, Y any, Z all
// - Short word is address plus 32768
// - Battery b means every 2^b frames
`timescale 1ns/1ps
`default_nettype none
module pac_conv
  import pac_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  input  wire logic [7:0]       in_char,
  input  wire logic             in_last,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic                  out_bad,
  output logic [ACC_W-1:0]      out_addr,
  output addr_class_e           out_cls,
  output logic                  out_one_word,
  output logic                  out_two_word,
  output logic                  out_std,
  output logic [7:0]            out_letter,
  output dev_class_e            out_dev,
  output logic [1:0]            out_phase,
  output logic                  out_phase_known,
  output logic [6:0]            out_frame,
  output logic                  out_frame_known,
  output logic [2:0]            out_batt,
  output logic                  out_batt_known,
  output logic [6:0]            out_look_mask,
  output logic                  out_ext,
  output logic [1:0]            out_ext_tag,
  output logic                  out_info_ok,
  output logic [20:0]           out_info,
  output logic                  out_disp_std,
  output logic [7:0]            out_disp_letter,
  output logic                  out_disp_batt
);
  // ****************
  // Parser state
  // ****************
  parse_e           st_r;      // Parse position
  logic             fin_r;     // Code complete, results next
  logic             ext_r;     // Extension letter seen
  logic [1:0]       etag_r;    // Extension letter index
  logic [2:0]       pcnt_r;    // Digits ahead of type letter
  logic [9:0]       facc_r;    // Prefix digits but the last
  logic [3:0]       last_r;    // Most recent prefix digit
  logic [7:0]       tl_r;      // Type letter
  logic [ACC_W-1:0] acc_r;     // Address value
  logic [3:0]       acnt_r;    // Address digit count
  logic             take;      // Character accepted
  // Character classes
  logic is_dig, is_std, is_nst, is_ext;
  assign is_dig = (in_char >= CH_0) && (in_char <= CH_9);
  assign is_std = (in_char >= CH_A) && (in_char <= CH_L);
  assign is_nst = (in_char >= CH_U) && (in_char <= CH_Z);
  assign is_ext = (in_char >= CH_P) && (in_char <= CH_S);
  // Stall only while results are formed
  assign in_ready = !fin_r;
  assign take = in_valid && in_ready;
  // ****************
  // Parser machine
  // ****************
  // Next parse position per character
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= PS_HEAD;
    end else if (fin_r) begin
      st_r <= PS_HEAD;
    end else if (take) begin
      case (st_r)
        PS_HEAD: begin
          if (is_ext && !ext_r) st_r <= PS_HEAD;
          else if (is_dig) st_r <= PS_PRE;
          else if (is_std || is_nst) st_r <= PS_ADDR;
          else st_r <= PS_BAD;
        end
        PS_PRE: begin
          if (is_dig) st_r <= PS_PRE;
          else if (is_std || is_nst) st_r <= PS_ADDR;
          else st_r <= PS_BAD;
        end
        PS_ADDR: begin
          if (!is_dig) st_r <= PS_BAD;
        end
        default: st_r <= PS_BAD;
      endcase
    end
  end
  // Completion flag, one cycle
  always_ff @(posedge clk) begin
    if (!rst_b) fin_r <= 1'b0;
    else fin_r <= take && in_last;
  end
  // Extension letter capture
  always_ff @(posedge clk) begin
    if (!rst_b || fin_r) begin
      ext_r  <= 1'b0;
      etag_r <= 2'h0;
    end else if (take && st_r == PS_HEAD && is_ext && !ext_r) begin
      ext_r  <= 1'b1;
      etag_r <= in_char[1:0];
    end
  end
  // Prefix digits: frame part and last digit
  always_ff @(posedge clk) begin
    if (!rst_b || fin_r) begin
      pcnt_r <= 3'h0;
      facc_r <= 10'h000;
      last_r <= 4'h0;
    end else if (take && is_dig && (st_r == PS_HEAD || st_r == PS_PRE)) begin
      if (pcnt_r != PRE_OVER) pcnt_r <= 3'(pcnt_r + 3'h1);
      facc_r <= 10'(facc_r * 10'h00A + {6'h00, last_r});
      last_r <= in_char[3:0];
    end
  end
  // Type letter capture
  always_ff @(posedge clk) begin
    if (!rst_b || fin_r) tl_r <= 8'h00;
    else if (take && (st_r == PS_HEAD || st_r == PS_PRE) && (is_std || is_nst))
      tl_r <= in_char;
  end
  // Decimal address accumulation
  always_ff @(posedge clk) begin
    if (!rst_b || fin_r) begin
      acc_r  <= '0;
      acnt_r <= 4'h0;
    end else if (take && st_r == PS_ADDR && is_dig) begin
      acc_r <= ACC_W'(acc_r * 34'h0_0000_000A + {30'h0, in_char[3:0]});
      if (acnt_r != LEN_OVER) acnt_r <= 4'(acnt_r + 4'h1);
    end
  end
  // ****************
  // Result forming
  // ****************
  logic             f_std;   // Standard embedding letter
  logic [1:0]       f_sub;   // Subtract amount
  logic [3:0]       f_idx;   // Standard letter index
  logic [ACC_W-1:0] f_adj;   // Adjusted address
  logic             f_pre_ok, f_len_ok, f_rng_ok;
  logic [2:0]       f_batt;
  logic             f_bk, f_fk, f_pk, f_match;
  logic [6:0]       f_frame;
  logic [1:0]       f_phase;
  dev_class_e       f_dev;
  addr_class_e      f_cls;
  // Decode of captured fields
  always_comb begin
    f_std = (tl_r >= CH_A) && (tl_r <= CH_L);
    // A/E/I take 0 up to D/H/L take 3
    f_sub = 2'(tl_r[1:0] - 2'h1);
    f_idx = 4'(tl_r[3:0] - 4'h1);
    f_adj = ACC_W'(acc_r - {32'h0, f_sub});
    if (f_std) f_pre_ok = (pcnt_r == 3'h0) ||
                          (pcnt_r == PRE_BATT && last_r <= BATT_MAX);
    else f_pre_ok = (pcnt_r == 3'h0) || (pcnt_r == PRE_FULL &&
                    facc_r <= FRAME_MAX && last_r <= BATT_MAX);
    f_len_ok = (acnt_r == LEN_SHORT || acnt_r == LEN_L12 ||
                acnt_r == LEN_LONG) && (!ext_r || acnt_r == LEN_LONG);
    f_rng_ok = (acc_r >= ADDR_MIN) && (acc_r <= ADDR_MAX) &&
               (!f_std || acc_r >= {32'h0, f_sub});
    if (acnt_r == LEN_SHORT) f_cls = CLS_SHORT;
    else if (acnt_r == LEN_L12) f_cls = CLS_L12;
    else f_cls = CLS_LONG;
    f_batt = BATT_DEF;
    f_bk = 1'b1;
    f_fk = 1'b1;
    f_pk = 1'b1;
    f_phase = 2'h0;
    f_frame = 7'h00;
    f_dev = DEV_SINGLE;
    f_match = 1'b0;
    if (f_std) begin
      f_phase = f_adj[PH_LSB +: 2];
      f_frame = f_adj[FR_LSB +: 7];
      f_dev = dev_class_e'(f_idx[3:2]);
      f_pk = (f_dev == DEV_SINGLE);
      if (pcnt_r == PRE_BATT) f_batt = last_r[2:0];
    end else begin
      if (tl_r <= CH_X) f_phase = 2'(tl_r[1:0] - 2'h1);
      if (tl_r == CH_Y) f_dev = DEV_ANY;
      else if (tl_r == CH_Z) f_dev = DEV_ALL;
      f_pk = (f_dev == DEV_SINGLE);
      f_fk = (pcnt_r == PRE_FULL);
      f_bk = f_fk;
      f_frame = f_fk ? facc_r[6:0] : 7'h00;
      f_batt = f_fk ? last_r[2:0] : 3'h0;
      // explicit data equal to standard rule
      f_match = f_fk && f_frame == acc_r[FR_LSB +: 7] &&
                (!f_pk || f_phase == acc_r[PH_LSB +: 2]);
    end
  end
  // Registered results, once per code
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_bad <= 1'b0;
      out_addr <= '0;
      out_cls <= CLS_SHORT;
      out_one_word <= 1'b0;
      out_two_word <= 1'b0;
      out_std <= 1'b0;
      out_letter <= 8'h00;
      out_dev <= DEV_SINGLE;
      out_phase <= 2'h0;
      out_phase_known <= 1'b0;
      out_frame <= 7'h00;
      out_frame_known <= 1'b0;
      out_batt <= 3'h0;
      out_batt_known <= 1'b0;
      out_look_mask <= 7'h00;
      out_ext <= 1'b0;
      out_ext_tag <= 2'h0;
      out_info_ok <= 1'b0;
      out_info <= 21'h00_0000;
      out_disp_std <= 1'b0;
      out_disp_letter <= 8'h00;
      out_disp_batt <= 1'b0;
    end else begin
      out_valid <= fin_r;
      if (fin_r) begin
        // any malformed part flags the code
        out_bad <= (st_r != PS_ADDR) || !f_pre_ok || !f_len_ok || !f_rng_ok;
        out_addr <= acc_r;
        out_cls <= f_cls;
        // one word and two word bands
        out_one_word <= acc_r < ONE_LIM;
        out_two_word <= acc_r > TWO_LIM;
        out_std <= f_std;
        out_letter <= tl_r;
        out_dev <= f_dev;
        out_phase <= f_phase;
        out_phase_known <= f_pk;
        out_frame <= f_frame;
        out_frame_known <= f_fk;
        out_batt <= f_batt;
        out_batt_known <= f_bk;
        out_look_mask <= 7'((8'h01 << f_batt) - 8'h01);
        out_ext <= ext_r;
        out_ext_tag <= etag_r;
        out_info_ok <= (f_cls == CLS_SHORT) && (acc_r < ONE_LIM);
        out_info <= 21'(acc_r[20:0] + SHORT_OFS);
        out_disp_std <= f_std || f_match;
        if (f_std) out_disp_letter <= tl_r;
        else if (f_dev == DEV_ANY) out_disp_letter <= CH_E;
        else if (f_dev == DEV_ALL) out_disp_letter <= CH_I;
        else out_disp_letter <= CH_A;
        out_disp_batt <= f_bk && (f_batt != BATT_DEF);
      end
    end
  end
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [1:0]       c_sub;
  logic [ACC_W-1:0] c_adj;
  logic             ok;
  assign c_sub = 2'(out_letter[1:0] - 2'h1);
  assign c_adj = ACC_W'(out_addr - {32'h0, c_sub});
  assign ok = out_valid && !out_bad;
  sequence s_last;
    take && in_last;
  endsequence
  sequence s_done;
    fin_r && !in_ready ##1 out_valid;
  endsequence
  a_result_timing: assert property (s_last |=> s_done)
    else $error("result not two cycles after last character");
  a_letter_sets: assert property (ok |-> out_std ==
    (out_letter >= CH_A && out_letter <= CH_L))
    else $error("letter kind mismatch");
  a_batt_default: assert property (ok && out_std &&
    $past(pcnt_r) == 3'h0 |-> out_batt == BATT_DEF)
    else $error("default battery not applied");
  a_frame_unknown: assert property (ok && !out_std &&
    $past(pcnt_r) == 3'h0 |-> !out_frame_known && !out_batt_known)
    else $error("explicit form without prefix reported known");
  a_ext_length: assert property (ok && out_ext |-> out_cls == CLS_LONG)
    else $error("extension with short field");
  a_class_len: assert property (ok && $past(acnt_r) == LEN_SHORT
    |-> out_cls == CLS_SHORT)
    else $error("seven digits not short class");
  a_addr_range: assert property (ok |-> out_addr >= ADDR_MIN &&
    out_addr <= ADDR_MAX)
    else $error("address out of range accepted");
  a_std_fields: assert property (ok && out_std |->
    out_phase == c_adj[PH_LSB +: 2] && out_frame == c_adj[FR_LSB +: 7])
    else $error("standard phase or frame wrong");
  a_std_group: assert property (ok && out_std |->
    out_dev == dev_class_e'(2'(4'(out_letter[3:0] - 4'h1) >> 2)))
    else $error("device class wrong");
  a_short_word: assert property (out_valid && out_info_ok |->
    out_info == 21'(out_addr[20:0] + SHORT_OFS))
    else $error("short word wrong");
  a_look_mask: assert property (out_valid |->
    out_look_mask == 7'((8'h01 << out_batt) - 8'h01))
    else $error("look mask wrong");
  a_disp_std: assert property (ok && out_std |-> out_disp_std &&
    out_disp_letter == out_letter)
    else $error("standard code not shown standard");
endmodule : pac_conv
`default_nettype wire

// File: testbench/pac_conv_tb.sv
// Self-checking bench for the pager address code converter
`timescale 1ns/1ps
`default_nettype none
module pac_conv_tb;
  import pac_pkg::*;
  // ****************
  // Stimulus and observed signals
  // ****************
  logic              clk, rst_b, in_valid, in_last;   // Clock, reset, strobes
  logic [7:0]        in_char;                          // Offered character
  logic              in_ready, out_valid, out_bad;     // Handshake and flag
  logic [ACC_W-1:0]  out_addr;                         // Decimal address
  addr_class_e       out_cls;                          // Address class
  dev_class_e        out_dev;                          // Device class
  logic              out_one_word, out_two_word, out_std, out_phase_known;
  logic              out_frame_known, out_batt_known, out_ext, out_info_ok;
  logic              out_disp_std, out_disp_batt;      // Display form flags
  logic [7:0]        out_letter, out_disp_letter;      // Letters
  logic [1:0]        out_phase, out_ext_tag;           // Phase, extension tag
  logic [6:0]        out_frame, out_look_mask;         // Frame, look mask
  logic [2:0]        out_batt;                         // Battery cycle
  logic [20:0]       out_info;                         // Short word field
  int                fails, n_checks, cyc;             // Counters
  pac_conv i_dut (.clk, .rst_b, .in_valid, .in_char, .in_last, .in_ready, .out_valid,
    .out_bad, .out_addr, .out_cls, .out_one_word, .out_two_word, .out_std, .out_letter,
    .out_dev, .out_phase, .out_phase_known, .out_frame, .out_frame_known, .out_batt,
    .out_batt_known, .out_look_mask, .out_ext, .out_ext_tag, .out_info_ok, .out_info,
    .out_disp_std, .out_disp_letter, .out_disp_batt);
  // ****************
  // Clock and hang guard
  // ****************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      test_done();
    end
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // Send one code, one character a cycle, then wait for the result pulse
  task automatic run(input string s);
    int i;
    for (i = 0; i < s.len(); i++) begin
      @(posedge clk);
      in_valid <= 1'b1;
      in_char  <= s[i];
      in_last  <= (i == s.len() - 1);
    end
    @(posedge clk);
    in_valid <= 1'b0;
    in_last  <= 1'b0;
    #1;
    chk("in_ready", in_ready, 1'b0);
    for (i = 0; i < 8 && out_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("out_valid", out_valid, 1'b1);
  endtask : run
  // Expected results of a standard-rule code: k is letter index from A
  task automatic chk_std(input longint a, input int k, input int b);
    longint j;
    j = a - k % 4;
    chk("bad", out_bad, 1'b0);
    chk("addr", out_addr, a);
    chk("std", out_std, 1'b1);
    chk("letter", out_letter, CH_A + k);
    chk("dev", out_dev, k / 4);
    chk("phase_known", out_phase_known, k < 4);
    if (k < 4) chk("phase", out_phase, (j / 4) % 4);
    chk("frame", out_frame, (j / 16) % 128);
    chk("frame_known", out_frame_known, 1'b1);
    chk("batt", out_batt, b);
    chk("batt_known", out_batt_known, 1'b1);
    chk("look_mask", out_look_mask, (1 << b) - 1);
  endtask : chk_std
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    @(posedge clk);
    #1;
    chk("in_ready", in_ready, 1'b1);
    chk("out_valid", out_valid, 1'b0);
    chk("out_addr", out_addr, 0);
    $display("t_reset finished");
  endtask : t_reset
  // No battery digit, short address: default cycle and info word
  task automatic t_std;
    string s;
    for (int k = 0; k < 12; k += 4) begin
      s = "A1234567";
      s[0] = 8'(CH_A + k);
      run(s);
      chk_std(1234567, k, 4);
      chk("cls", out_cls, CLS_SHORT);
      chk("info_ok", out_info_ok, 1'b1);
      chk("info", out_info, 1234567 + 32768);
    end
    $display("t_std finished");
  endtask : t_std
  // Reset in mid code clears the parser and results
  task automatic t_mid_reset;
    @(posedge clk);
    in_valid <= 1'b1;
    in_char  <= CH_A;
    in_last  <= 1'b0;
    @(posedge clk);
    in_char  <= CH_0;
    @(posedge clk);
    rst_b    <= 1'b0;
    in_valid <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b    <= 1'b1;
    t_reset();
    run("A0000016");
    chk_std(16, 0, 4);
    $display("t_mid_reset finished");
  endtask : t_mid_reset
  // second addresses take B F J
  task automatic t_batt;
    string s;
    for (int k = 1; k < 12; k += 4) begin
      s = "3B1234560";
      s[1] = 8'(CH_A + k);
      run(s);
      chk_std(1234560, k, 3);
      chk("disp_std", out_disp_std, 1'b1);
      chk("disp_letter", out_disp_letter, CH_A + k);
      chk("disp_batt", out_disp_batt, 1'b1);
    end
    run("7D1234562");
    chk_std(1234562, 3, 7);
    run("4C1234567");
    chk_std(1234567, 2, 4);
    chk("disp_batt", out_disp_batt, 1'b0);
    $display("t_batt finished");
  endtask : t_batt
  // Explicit letters: fixed phases, optional frame and battery
  task automatic t_explicit;
    string s;
    for (int p = 0; p < 4; p++) begin
      s = "U1234567";
      s[0] = 8'(CH_U + p);
      run(s);
      chk("bad", out_bad, 1'b0);
      chk("std", out_std, 1'b0);
      chk("dev", out_dev, DEV_SINGLE);
      chk("phase", out_phase, p);
      chk("phase_known", out_phase_known, 1'b1);
      chk("frame_known", out_frame_known, 1'b0);
      chk("batt_known", out_batt_known, 1'b0);
      chk("disp_std", out_disp_std, 1'b0);
    end
    run("X0000002");
    chk("bad", out_bad, 1'b0);
    chk("phase", out_phase, 3);
    run("Y1234567");
    chk("dev", out_dev, DEV_ANY);
    chk("phase_known", out_phase_known, 1'b0);
    chk("frame_known", out_frame_known, 1'b0);
    run("0413V1234567");
    chk("bad", out_bad, 1'b0);
    chk("frame", out_frame, 41);
    chk("frame_known", out_frame_known, 1'b1);
    chk("batt", out_batt, 3);
    chk("batt_known", out_batt_known, 1'b1);
    chk("look_mask", out_look_mask, 7);
    chk("disp_std", out_disp_std, 1'b0);
    run("1043V1234567");
    chk("phase", out_phase, 1);
    chk("frame", out_frame, 104);
    chk("disp_std", out_disp_std, 1'b1);
    chk("disp_letter", out_disp_letter, CH_A);
    chk("disp_batt", out_disp_batt, 1'b1);
    run("1044Z1234567");
    chk("dev", out_dev, DEV_ALL);
    chk("disp_std", out_disp_std, 1'b1);
    chk("disp_letter", out_disp_letter, CH_I);
    chk("disp_batt", out_disp_batt, 1'b0);
    $display("t_explicit finished");
  endtask : t_explicit
  // Long fields, extension letter and range edges
  task automatic t_long;
    run("A123456789");
    chk_std(123456789, 0, 4);
    chk("cls", out_cls, CLS_L12);
    chk("one_word", out_one_word, 1'b0);
    chk("two_word", out_two_word, 1'b1);
    chk("info_ok", out_info_ok, 1'b0);
    chk("ext", out_ext, 1'b0);
    run("RA1234567890");
    chk_std(1234567890, 0, 4);
    chk("cls", out_cls, CLS_LONG);
    chk("ext", out_ext, 1'b1);
    chk("ext_tag", out_ext_tag, 2);
    run("SI5370810366");
    chk_std(64'd5370810366, 8, 4);
    chk("ext_tag", out_ext_tag, 3);
    run("A0000001");
    chk_std(1, 0, 4);
    chk("one_word", out_one_word, 1'b1);
    chk("two_word", out_two_word, 1'b0);
    chk("info_ok", out_info_ok, 1'b1);
    chk("info", out_info, 1 + 32768);
    run("A2050000");
    chk("bad", out_bad, 1'b0);
    chk("one_word", out_one_word, 1'b0);
    chk("two_word", out_two_word, 1'b0);
    chk("info_ok", out_info_ok, 1'b0);
    $display("t_long finished");
  endtask : t_long
  // Twelve malformed codes, each with a different fault, raise the flag
  task automatic t_bad;
    string codes [12] = '{"M1234567", "12A1234567", "8A1234567", "1284U1234567",
                          "041U1234567", "A123456", "A12B4567", "D0000002", "A0000000",
                          "A5370810367", "PA123456789", "PQA1234567890"};
    foreach (codes[i]) begin
      run(codes[i]);
      chk("bad", out_bad, 1'b1);
    end
    $display("t_bad finished");
  endtask : t_bad
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // ****************
  // Test sequence
  // ****************
  initial begin
    rst_b    <= 1'b0;
    in_valid <= 1'b0;
    in_char  <= 8'h00;
    in_last  <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b    <= 1'b1;
    t_reset();
    t_std();
    t_mid_reset();
    t_batt();
    t_explicit();
    t_long();
    t_bad();
    test_done();
  end
endmodule : pac_conv_tb
`default_nettype wire
